// ===== verilog/ssm_map.svh
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH
// ----------------------------------------
// Device register indices (byte addr = 4 x index)
// ----------------------------------------
`define SSM_IDX_FLAGS 8'h0c
`define SSM_IDX_BUF 8'h13
`define SSM_IDX_CTRL 8'h14
`define SSM_IDX_DIR_A 8'h85
`define SSM_IDX_DIR_C 8'h87
`define SSM_IDX_ENABLES 8'h8c
`define SSM_IDX_STATUS 8'h94
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SSM_CTRL_WRITE_COLLISION_FLAG 7
`define SSM_CTRL_OV 6
`define SSM_CTRL_EN 5
`define SSM_CTRL_CKP 4
`define SSM_STAT_SMP 7
`define SSM_STAT_CKE 6
`define SSM_IRQ_BIT 3
`define SSM_DIR_SCK 3
`define SSM_DIR_SDI 4
`define SSM_DIR_SDO 5
`define SSM_DIR_SS 5
`define SSM_DIR_RESET 8'h3f
`define SSM_MODE_RESET 4'h0
// ----------------------------------------
// Master half bit periods in pclk cycles
// ----------------------------------------
`define SSM_HALF_DIV4 6'h02
`define SSM_HALF_DIV16 6'h08
`define SSM_HALF_DIV64 6'h20
// ----------------------------------------
// Peer controller registers
// ----------------------------------------
`define SSM_PEER_CTRL 12'h000
`define SSM_PEER_TX 12'h004
`define SSM_PEER_RX 12'h008
`define SSM_PEER_STAT 12'h00c
`define SSM_PEER_HALF_RESET 8'h08
`endif

// ===== verilog/ssm_pkg.sv
package ssm_pkg;
	typedef logic [11:0] ssm_addr_t;
	typedef logic [31:0] ssm_word_t;
	typedef logic [7:0] ssm_byte_t;
	typedef enum logic [3:0] {
		SSM_MASTER_DIV4 = 4'h0,
		SSM_MASTER_DIV16 = 4'h1,
		SSM_MASTER_DIV64 = 4'h2,
		SSM_MASTER_TIMER = 4'h3,
		SSM_SLAVE_SEL = 4'h4,
		SSM_SLAVE_FREE = 4'h5
	} ssm_mode_t;
endpackage

// ===== verilog/ssm_link_if.sv
`timescale 1ns/1ps
interface ssm_link_if;
	logic dev_sck_o, dev_sck_oe, dev_sdo_o, dev_sdo_oe;
	logic peer_sck_o, peer_sck_oe, peer_sdo_o, peer_sdo_oe;
	logic peer_ss_n_o;
	logic sck, dev_sdi, peer_sdi, ss_n;
	// ----------------------------------------
	// Wire levels, pull-ups hold idle lines high
	// ----------------------------------------
	assign sck = dev_sck_oe ? dev_sck_o :
		(peer_sck_oe ? peer_sck_o : 1'h1);
	assign dev_sdi = peer_sdo_oe ? peer_sdo_o : 1'h1;
	assign peer_sdi = dev_sdo_oe ? dev_sdo_o : 1'h1;
	assign ss_n = peer_ss_n_o;
	modport dev (output dev_sck_o, dev_sck_oe, dev_sdo_o, dev_sdo_oe,
		input sck, dev_sdi, ss_n);
	modport peer (output peer_sck_o, peer_sck_oe, peer_sdo_o,
		peer_sdo_oe, peer_ss_n_o, input sck, peer_sdi);
endinterface // ssm_link_if

// ===== verilog/ssm_port.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "ssm_map.svh"
// Operation
// - Port runs only while enable bit set
// - Software sets pin directions per role
// - Opposite direction bit overrides serial function, except slave clock input
// - Shift on one edge, capture on other
// - Master buffer write starts 8-bit exchange
// - Receive-only master keeps shifting bytes in
// - Slave shifts on external clock, flags byte
// - Clock idles at polarity bit, MSB first
// - Master rate osc/4, /16, /64, timer/2
// - Fastest divider master bit clock is osc/4; timer mode toggles on each timer_tick, so osc/2 if it ticks every cycle
// - Slave runs in sleep, completion wakes
// - Select gating needs mode 4, input direction
// - Select high floats data output at once
// - Select high resets slave transfer logic
// - Slave with edge bit set needs select
// - Output pin as input stops transmission
// - Mode field picks master rate or slave
// - Busy buffer write dropped, sets collision flag
// - Received byte sets full, read clears
// - Slave overrun sets overflow, drops byte
module ssm_port (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire ssm_pkg::ssm_addr_t paddr,
	input wire ssm_pkg::ssm_word_t pwdata,
	output ssm_pkg::ssm_word_t prdata,
	output logic pready,
	output logic pslverr,
	// System
	input wire logic sleep_mode,
	input wire logic timer_tick,
	output logic wake_req,
	// Serial link
	ssm_link_if.dev link
);
	import ssm_pkg::*;

	// ----------------------------------------
	// Register bus decode
	// ----------------------------------------
	logic write_collision_flag_q, ov_q, en_q, ckp_q, smp_q, cke_q, bf_q;
	logic irqf_q, irqe_q, wake_q;
	ssm_mode_t mode_q;
	ssm_byte_t buf_q, dira_q, dirc_q, sr_q, rd_byte;
	ssm_word_t prdata_q;
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire rd = acc & !pwrite;
	wire [7:0] idx = paddr[9:2];
	wire aligned = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0;
	wire hit_flags = aligned && idx == `SSM_IDX_FLAGS;
	wire hit_buf = aligned && idx == `SSM_IDX_BUF;
	wire hit_ctrl = aligned && idx == `SSM_IDX_CTRL;
	wire hit_da = aligned && idx == `SSM_IDX_DIR_A;
	wire hit_dc = aligned && idx == `SSM_IDX_DIR_C;
	wire hit_en = aligned && idx == `SSM_IDX_ENABLES;
	wire hit_stat = aligned && idx == `SSM_IDX_STATUS;
	wire mapped = hit_flags | hit_buf | hit_ctrl | hit_da | hit_dc |
		hit_en | hit_stat;
	assign rd_byte = hit_flags ? {4'h0, irqf_q, 3'h0} :
		hit_buf ? buf_q :
		hit_ctrl ? {write_collision_flag_q, ov_q, en_q, ckp_q, mode_q} :
		hit_da ? dira_q :
		hit_dc ? dirc_q :
		hit_en ? {4'h0, irqe_q, 3'h0} :
		hit_stat ? {smp_q, cke_q, 5'h00, bf_q} : 8'h00;
	assign pready = 1'h1;
	assign pslverr = acc & !mapped;
	assign prdata = prdata_q;
	assign wake_req = wake_q;

	// ----------------------------------------
	// Synchronisers for the pins
	// ----------------------------------------
	logic sck_m, sck_s, sck_p, sdi_m, sdi_s, ss_m, ss_s;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Pin idles high through its pull-up, so no false edge
			sck_m <= 1'h1;
			sck_s <= 1'h1;
			sck_p <= 1'h1;
			sdi_m <= 1'h0;
			sdi_s <= 1'h0;
			ss_m <= 1'h1;
			ss_s <= 1'h1;
		end else begin
			sck_m <= link.sck;
			sck_s <= sck_m;
			sck_p <= sck_s;
			sdi_m <= link.dev_sdi;
			sdi_s <= sdi_m;
			ss_m <= link.ss_n;
			ss_s <= ss_m;
		end
	end

	// ----------------------------------------
	// Mode and pin functions
	// ----------------------------------------
	logic busy_q, sck_q, cap_q;
	logic [2:0] cnt_q;
	logic [5:0] div_q;
	wire is_master = en_q & mode_q[3:2] == 2'h0;
	wire is_slave = en_q & (mode_q == SSM_SLAVE_SEL ||
		mode_q == SSM_SLAVE_FREE);
	wire ss_gate = mode_q == SSM_SLAVE_SEL & dira_q[`SSM_DIR_SS];
	wire ss_block = is_slave & ss_gate & ss_s;
	wire run_rst = !en_q | ss_block;
	wire sdi_v = dirc_q[`SSM_DIR_SDI] & sdi_s;
	wire rx_only = is_master & dirc_q[`SSM_DIR_SCK];
	assign link.dev_sck_o = sck_q;
	assign link.dev_sck_oe = is_master & !dirc_q[`SSM_DIR_SCK];
	assign link.dev_sdo_o = sr_q[7];
	// Float immediately on select, even mid-byte
	assign link.dev_sdo_oe = (is_master | is_slave) &
		!dirc_q[`SSM_DIR_SDO] & !ss_block;

	// ----------------------------------------
	// Bit clock and edges
	// ----------------------------------------
	wire [5:0] half = mode_q == SSM_MASTER_DIV4 ? `SSM_HALF_DIV4 :
		mode_q == SSM_MASTER_DIV16 ? `SSM_HALF_DIV16 :
		`SSM_HALF_DIV64;
	wire div_end = div_q == half - 6'h01;
	wire tick_m = busy_q & is_master & !run_rst &
		(mode_q == SSM_MASTER_TIMER ? timer_tick : div_end);
	wire lead_m = tick_m & (sck_q == ckp_q);
	wire trail_m = tick_m & (sck_q != ckp_q);
	wire rise_s = sck_s & !sck_p;
	wire fall_s = !sck_s & sck_p;
	wire slv_ok = is_slave & !run_rst;
	wire lead_s = slv_ok & (ckp_q ? fall_s : rise_s);
	wire trail_s = slv_ok & (ckp_q ? rise_s : fall_s);
	wire lead = lead_m | lead_s;
	wire trail = trail_m | trail_s;
	wire cap_ev = cke_q ? trail : lead;
	wire shift_ev = cke_q ? lead & cnt_q != 3'h0 : trail;
	wire done_ev = trail & cnt_q == 3'h7;
	// Late sample takes the pin at the shift edge itself
	wire late = trail & (cke_q | (is_master & smp_q));
	wire new_bit = late ? sdi_v : cap_q;
	wire [7:0] next_byte = {sr_q[6:0], new_bit};
	wire xfer_act = busy_q | cnt_q != 3'h0;
	wire wr_buf = wr & hit_buf;
	wire start = wr_buf & !xfer_act;
	wire ovf_ev = done_ev & is_slave & bf_q;
	wire load_ev = done_ev & !ovf_ev;
	// Idle level follows a polarity write at once, no glitch on enable
	wire ckp_next = (wr & hit_ctrl) ? pwdata[`SSM_CTRL_CKP] : ckp_q;

	// ----------------------------------------
	// Shift engine
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_q <= 8'h00;
			cap_q <= 1'h0;
			cnt_q <= 3'h0;
			busy_q <= 1'h0;
			div_q <= 6'h00;
			sck_q <= 1'h0;
		end else if (run_rst) begin
			if (start)
				sr_q <= pwdata[7:0];
			cnt_q <= 3'h0;
			busy_q <= 1'h0;
			div_q <= 6'h00;
			sck_q <= ckp_next;
		end else begin
			if (start)
				sr_q <= pwdata[7:0];
			else if (shift_ev | done_ev)
				sr_q <= next_byte;
			if (cap_ev)
				cap_q <= sdi_v;
			if (trail)
				cnt_q <= cnt_q + 3'h1;
			busy_q <= (start & is_master) | rx_only |
				(busy_q & !done_ev);
			div_q <= (!busy_q | div_end) ? 6'h00 : div_q + 6'h01;
			if (!busy_q)
				sck_q <= ckp_next;
			else if (tick_m)
				sck_q <= !sck_q;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 1'h0;
			ckp_q <= 1'h0;
			mode_q <= ssm_mode_t'(`SSM_MODE_RESET);
			smp_q <= 1'h0;
			cke_q <= 1'h0;
			irqe_q <= 1'h0;
			dira_q <= `SSM_DIR_RESET;
			dirc_q <= `SSM_DIR_RESET;
		end else if (wr) begin
			if (hit_ctrl) begin
				en_q <= pwdata[`SSM_CTRL_EN];
				ckp_q <= pwdata[`SSM_CTRL_CKP];
				mode_q <= ssm_mode_t'(pwdata[3:0]);
			end
			if (hit_stat) begin
				smp_q <= pwdata[`SSM_STAT_SMP];
				cke_q <= pwdata[`SSM_STAT_CKE];
			end
			if (hit_en)
				irqe_q <= pwdata[`SSM_IRQ_BIT];
			if (hit_da)
				dira_q <= pwdata[7:0];
			if (hit_dc)
				dirc_q <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// Status flags, set beats clear
	// ----------------------------------------
	wire wr_ctrl = wr & hit_ctrl;
	wire wr_flags = wr & hit_flags;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_collision_flag_q <= 1'h0;
			ov_q <= 1'h0;
			bf_q <= 1'h0;
			irqf_q <= 1'h0;
			buf_q <= 8'h00;
			wake_q <= 1'h0;
			prdata_q <= 32'h00000000;
		end else begin
			write_collision_flag_q <= (wr_buf & xfer_act) |
				(wr_ctrl ? pwdata[`SSM_CTRL_WRITE_COLLISION_FLAG] : write_collision_flag_q);
			ov_q <= ovf_ev |
				(wr_ctrl ? pwdata[`SSM_CTRL_OV] : ov_q);
			bf_q <= load_ev | (bf_q & !(rd & hit_buf));
			irqf_q <= done_ev |
				(wr_flags ? pwdata[`SSM_IRQ_BIT] : irqf_q);
			if (load_ev)
				buf_q <= next_byte;
			wake_q <= sleep_mode & is_slave & irqf_q & irqe_q;
			if (psel & !penable)
				prdata_q <= {24'h000000, rd_byte};
		end
	end
endmodule // ssm_port

// ===== verilog/ssm_peer.sv
`timescale 1ns/1ps
`include "ssm_map.svh"
module ssm_peer (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire ssm_pkg::ssm_addr_t paddr,
	input wire ssm_pkg::ssm_word_t pwdata,
	output ssm_pkg::ssm_word_t prdata,
	output logic pready,
	output logic pslverr,
	// Serial link
	ssm_link_if.peer link
);
	import ssm_pkg::*;

	// ----------------------------------------
	// Register bus decode
	// ----------------------------------------
	logic en_q, mst_q, ckp_q, cke_q, busy_q, tail_q, done_q, sck_q;
	logic cap_q, sck_m, sck_s, sck_p, sdi_m, sdi_s;
	logic [7:0] half_q, div_q;
	logic [2:0] cnt_q;
	ssm_byte_t sr_q, rx_q;
	ssm_word_t prdata_q, rd_word;
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire hit_ctrl = paddr == `SSM_PEER_CTRL;
	wire hit_tx = paddr == `SSM_PEER_TX;
	wire hit_rx = paddr == `SSM_PEER_RX;
	wire hit_stat = paddr == `SSM_PEER_STAT;
	assign rd_word = hit_ctrl ? {16'h0000, half_q, 4'h0, cke_q, ckp_q,
		mst_q, en_q} :
		hit_rx ? {24'h000000, rx_q} :
		hit_stat ? {30'h00000000, done_q, busy_q} : 32'h00000000;
	assign pready = 1'h1;
	assign pslverr = acc & !(hit_ctrl | hit_tx | hit_rx | hit_stat);
	assign prdata = prdata_q;

	// ----------------------------------------
	// Pins and edges
	// ----------------------------------------
	wire act = en_q & (busy_q | !mst_q);
	wire div_end = div_q == half_q - 8'h01;
	wire tick = en_q & mst_q & busy_q & div_end;
	wire tick_run = tick & !tail_q;
	wire rise = sck_s & !sck_p;
	wire fall = !sck_s & sck_p;
	wire slv = en_q & !mst_q;
	wire lead = (tick_run & sck_q == ckp_q) |
		(slv & (ckp_q ? fall : rise));
	wire trail = (tick_run & sck_q != ckp_q) |
		(slv & (ckp_q ? rise : fall));
	wire cap_ev = cke_q ? trail : lead;
	wire shift_ev = cke_q ? lead & cnt_q != 3'h0 : trail;
	wire done_ev = trail & cnt_q == 3'h7;
	wire new_bit = (trail & cke_q) ? sdi_s : cap_q;
	wire [7:0] next_byte = {sr_q[6:0], new_bit};
	wire start = wr & hit_tx & !busy_q & cnt_q == 3'h0;
	wire ckp_next = (wr & hit_ctrl) ? pwdata[2] : ckp_q;
	assign link.peer_sck_o = sck_q;
	assign link.peer_sck_oe = en_q & mst_q;
	assign link.peer_sdo_o = sr_q[7];
	assign link.peer_sdo_oe = act;
	// Select stays low a half bit past the last edge
	assign link.peer_ss_n_o = !(en_q & mst_q & busy_q);

	// ----------------------------------------
	// Synchronisers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_m <= 1'h1;
			sck_s <= 1'h1;
			sck_p <= 1'h1;
			sdi_m <= 1'h0;
			sdi_s <= 1'h0;
		end else begin
			sck_m <= link.sck;
			sck_s <= sck_m;
			sck_p <= sck_s;
			sdi_m <= link.peer_sdi;
			sdi_s <= sdi_m;
		end
	end

	// ----------------------------------------
	// Control and shift engine
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 1'h0;
			mst_q <= 1'h0;
			ckp_q <= 1'h0;
			cke_q <= 1'h0;
			half_q <= `SSM_PEER_HALF_RESET;
		end else if (wr & hit_ctrl) begin
			en_q <= pwdata[0];
			mst_q <= pwdata[1];
			ckp_q <= pwdata[2];
			cke_q <= pwdata[3];
			half_q <= (pwdata[15:8] == 8'h00) ? 8'h01 : pwdata[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_q <= 8'h00;
			cap_q <= 1'h0;
			cnt_q <= 3'h0;
			busy_q <= 1'h0;
			tail_q <= 1'h0;
			div_q <= 8'h00;
			sck_q <= 1'h0;
		end else if (!en_q) begin
			cnt_q <= 3'h0;
			busy_q <= 1'h0;
			tail_q <= 1'h0;
			sck_q <= ckp_next;
		end else begin
			if (start)
				sr_q <= pwdata[7:0];
			else if (shift_ev | done_ev)
				sr_q <= next_byte;
			if (cap_ev)
				cap_q <= sdi_s;
			if (trail)
				cnt_q <= cnt_q + 3'h1;
			busy_q <= (start & mst_q) | (busy_q & !(tick & tail_q));
			tail_q <= (tail_q & !tick) | (done_ev & mst_q);
			div_q <= (!busy_q | div_end) ? 8'h00 : div_q + 8'h01;
			if (!busy_q)
				sck_q <= ckp_next;
			else if (tick_run)
				sck_q <= !sck_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_q <= 8'h00;
			done_q <= 1'h0;
			prdata_q <= 32'h00000000;
		end else begin
			if (done_ev)
				rx_q <= next_byte;
			done_q <= done_ev | (done_q & !(acc & !pwrite & hit_rx));
			if (psel & !penable)
				prdata_q <= rd_word;
		end
	end
endmodule // ssm_peer

// ===== verification/ssm_link_asserts.sv
`timescale 1ns/1ps
module ssm_link_asserts (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link
	input wire logic dev_sck_o,
	input wire logic dev_sck_oe,
	input wire logic dev_sdo_oe,
	input wire logic peer_sck_o,
	input wire logic peer_sck_oe,
	input wire logic ss_n
);
	logic sck_prev_q;
	logic [4:0] tog_q;
	logic [4:0] tog_d;
	logic [5:0] idle_q;
	logic [5:0] idle_d;
	// Only a driven clock counts, a released pin carries no bits
	wire logic sck_edge = dev_sck_oe && dev_sck_o != sck_prev_q;
	wire logic idle_full = idle_q == 6'h28;
	// Long quiet spell marks a byte boundary
	assign tog_d = sck_edge ? tog_q + 5'h01 : (idle_full ? 5'h00 : tog_q);
	assign idle_d = sck_edge ? 6'h00 : (idle_full ? idle_q : idle_q + 6'h01);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_prev_q <= 1'h0;
			tog_q <= 5'h00;
			idle_q <= 6'h00;
		end else begin
			sck_prev_q <= dev_sck_o;
			tog_q <= tog_d;
			idle_q <= idle_d;
		end
	end
	// ----------------------------------------
	// Link properties
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sck_excl_a: assert property (!(dev_sck_oe && peer_sck_oe))
		else $error("both ends drive the clock");
	dev_half_a: assert property (dev_sck_oe && $changed(dev_sck_o)
		|=> $stable(dev_sck_o)) else $error("master clock too fast");
	peer_half_a: assert property (peer_sck_oe && $changed(peer_sck_o)
		|=> $stable(peer_sck_o) [*2]) else $error("peer clock too fast");
	sel_low_a: assert property (peer_sck_oe && $changed(peer_sck_o)
		|-> !ss_n) else $error("clock toggles while deselected");
	sel_gap_a: assert property ($rose(ss_n)
		|-> $past(peer_sck_o, 2) == peer_sck_o)
		else $error("select released on a clock edge");
	sdo_float_a: assert property ((!dev_sck_oe && ss_n) [*4]
		|-> !dev_sdo_oe) else $error("data out driven while deselected");
	sdo_drive_a: assert property ($fell(ss_n) ##4 !ss_n
		|-> dev_sdo_oe) else $error("data out not driven when selected");
	byte_cnt_a: assert property (tog_q <= 5'h10)
		else $error("more than sixteen clock edges in a byte");
	cover property (tog_q == 5'h10);
	cover property ($rose(ss_n));
	cover property (peer_sck_oe && $changed(peer_sck_o));
endmodule // ssm_link_asserts

// ===== verification/tb.sv
`timescale 1ns/1ps
`include "ssm_map.svh"
module tb;
	import ssm_pkg::*;
	localparam ssm_addr_t A_FLG = {2'h0, `SSM_IDX_FLAGS, 2'h0};
	localparam ssm_addr_t A_BUF = {2'h0, `SSM_IDX_BUF, 2'h0};
	localparam ssm_addr_t A_CTL = {2'h0, `SSM_IDX_CTRL, 2'h0};
	localparam ssm_addr_t A_DRA = {2'h0, `SSM_IDX_DIR_A, 2'h0};
	localparam ssm_addr_t A_DRC = {2'h0, `SSM_IDX_DIR_C, 2'h0};
	localparam ssm_addr_t A_ENA = {2'h0, `SSM_IDX_ENABLES, 2'h0};
	localparam ssm_addr_t A_STA = {2'h0, `SSM_IDX_STATUS, 2'h0};
	logic pclk, presetn, psel_d, psel_p, penable, pwrite;
	logic sleep_mode, timer_tick, pready_d, pready_p, err_d, err_p;
	logic wake_req, last_err;
	ssm_addr_t paddr;
	ssm_word_t pwdata, prdata_d, prdata_p, rdata;
	int failures, checks_done;
	ssm_link_if ssm_link_if_i();
	ssm_port ssm_port_i(.pclk(pclk), .presetn(presetn), .psel(psel_d),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_d), .pready(pready_d), .pslverr(err_d),
		.sleep_mode(sleep_mode), .timer_tick(timer_tick),
		.wake_req(wake_req), .link(ssm_link_if_i));
	ssm_peer ssm_peer_i(.pclk(pclk), .presetn(presetn), .psel(psel_p),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata_p), .pready(pready_p), .pslverr(err_p),
		.link(ssm_link_if_i));
	ssm_link_asserts ssm_link_asserts_i(.pclk(pclk), .presetn(presetn),
		.dev_sck_o(ssm_link_if_i.dev_sck_o),
		.dev_sck_oe(ssm_link_if_i.dev_sck_oe),
		.dev_sdo_oe(ssm_link_if_i.dev_sdo_oe),
		.peer_sck_o(ssm_link_if_i.peer_sck_o),
		.peer_sck_oe(ssm_link_if_i.peer_sck_oe), .ss_n(ssm_link_if_i.ss_n));
	initial begin
		pclk = 1'h0;
		forever #2.5 pclk = ~pclk;
	end
	// ----------------------------------------
	// Bus and compare helpers
	// ----------------------------------------
	task automatic apb(input logic dev, input logic wr, input ssm_addr_t a,
		input ssm_word_t d);
		@(posedge pclk);
		psel_d <= dev;
		psel_p <= !dev;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while ((dev ? pready_d : pready_p) !== 1'h1);
		rdata = dev ? prdata_d : prdata_p;
		last_err = dev ? err_d : err_p;
		psel_d <= 1'h0;
		psel_p <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic chk(input string nm, input ssm_word_t e, input ssm_word_t g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic dev, input ssm_addr_t a, input ssm_word_t e,
		input string nm);
		apb(dev, 1'h0, a, 32'h0);
		chk(nm, e, rdata);
	endtask
	// Polling is bounded so a dead link shows as a failed compare
	task automatic wait_set(input logic dev, input ssm_addr_t a,
		input ssm_word_t m);
		for (int i = 0; i < 400; i++) begin
			apb(dev, 1'h0, a, 32'h0);
			if ((rdata & m) === m) break;
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(1'h1, A_CTL, 32'h0, "control");
		rd(1'h1, A_STA, 32'h0, "status");
		rd(1'h1, A_DRC, 32'h3f, "dir_c");
		rd(1'h1, A_DRA, 32'h3f, "dir_a");
		rd(1'h1, A_FLG, 32'h0, "flags");
		rd(1'h1, A_ENA, 32'h0, "enables");
		rd(1'h1, 12'h3fc, 32'h0, "unmapped data");
		chk("unmapped err", 32'h1, {31'h0, last_err});
		for (int m = 0; m < 6; m++) begin
			apb(1'h1, 1'h1, A_CTL, ssm_word_t'(m));
			rd(1'h1, A_CTL, ssm_word_t'(m), "mode");
		end
		apb(1'h1, 1'h1, A_CTL, 32'h0);
		$display("t_reset done");
	endtask
	task automatic t_master();
		apb(1'h1, 1'h1, A_DRC, 32'h17);
		apb(1'h1, 1'h1, A_CTL, 32'h21);
		@(posedge pclk);
		chk("idle low", 32'h0, {31'h0, ssm_link_if_i.dev_sck_o});
		// Slave joins once the clock idles, else it counts a false edge
		apb(1'h0, 1'h1, `SSM_PEER_CTRL, 32'h1);
		apb(1'h0, 1'h1, `SSM_PEER_TX, 32'h3c);
		apb(1'h1, 1'h1, A_BUF, 32'ha5);
		apb(1'h1, 1'h1, A_BUF, 32'h11);
		wait_set(1'h1, A_STA, 32'h1);
		rd(1'h1, A_CTL, 32'ha1, "collision");
		rd(1'h1, A_FLG, 32'h08, "irq flag");
		rd(1'h1, A_BUF, 32'h3c, "master rx");
		rd(1'h1, A_STA, 32'h0, "full cleared");
		rd(1'h0, `SSM_PEER_RX, 32'ha5, "peer rx");
		apb(1'h1, 1'h1, A_CTL, 32'h0);
		$display("t_master done");
	endtask
	task automatic t_slave();
		apb(1'h1, 1'h1, A_FLG, 32'h0);
		apb(1'h1, 1'h1, A_DRC, 32'h1f);
		apb(1'h1, 1'h1, A_ENA, 32'h08);
		apb(1'h1, 1'h1, A_CTL, 32'h24);
		apb(1'h1, 1'h1, A_BUF, 32'h5a);
		sleep_mode <= 1'h1;
		apb(1'h0, 1'h1, `SSM_PEER_CTRL, 32'h0803);
		apb(1'h0, 1'h1, `SSM_PEER_TX, 32'h96);
		wait_set(1'h1, A_FLG, 32'h08);
		chk("wake", 32'h1, {31'h0, wake_req});
		wait_set(1'h0, `SSM_PEER_STAT, 32'h2);
		rd(1'h0, `SSM_PEER_RX, 32'h5a, "slave tx");
		apb(1'h0, 1'h1, `SSM_PEER_TX, 32'h77);
		wait_set(1'h1, A_CTL, 32'h40);
		rd(1'h1, A_CTL, 32'h64, "overflow");
		rd(1'h1, A_BUF, 32'h96, "kept byte");
		sleep_mode <= 1'h0;
		apb(1'h1, 1'h1, A_CTL, 32'h0);
		apb(1'h0, 1'h1, `SSM_PEER_CTRL, 32'h0);
		$display("t_slave done");
	endtask
	task automatic t_abort();
		apb(1'h1, 1'h1, A_DRC, 32'h17);
		apb(1'h1, 1'h1, A_CTL, 32'h31);
		@(posedge pclk);
		chk("idle high", 32'h1, {31'h0, ssm_link_if_i.dev_sck_o});
		apb(1'h1, 1'h1, A_BUF, 32'hff);
		apb(1'h1, 1'h1, A_CTL, 32'h11);
		@(posedge pclk);
		chk("released", 32'h0, {31'h0, ssm_link_if_i.dev_sck_oe});
		apb(1'h1, 1'h1, A_CTL, 32'h31);
		apb(1'h1, 1'h1, A_BUF, 32'h0f);
		rd(1'h1, A_CTL, 32'h31, "no collision");
		apb(1'h1, 1'h1, A_CTL, 32'h0);
		$display("t_abort done");
	endtask
	// Pins given back to the port; the idle data line reads high
	task automatic t_rx_only();
		apb(1'h1, 1'h1, A_DRC, 32'h3f);
		apb(1'h1, 1'h1, A_CTL, 32'h20);
		@(posedge pclk);
		chk("sck released", 32'h0, {31'h0, ssm_link_if_i.dev_sck_oe});
		chk("sdo released", 32'h0, {31'h0, ssm_link_if_i.dev_sdo_oe});
		wait_set(1'h1, A_STA, 32'h1);
		rd(1'h1, A_BUF, 32'hff, "rx only");
		rd(1'h1, A_FLG, 32'h08, "rx only irq");
		apb(1'h1, 1'h1, A_CTL, 32'h0);
		$display("t_rx_only done");
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		presetn = 1'h0;
		psel_d = 1'h0;
		psel_p = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sleep_mode = 1'h0;
		timer_tick = 1'h0;
		failures = 0;
		checks_done = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_master();
		t_slave();
		t_abort();
		t_rx_only();
		summarize();
	end
	// Whole run needs several hundred cycles
	initial begin
		repeat (40000) @(posedge pclk);
		failures++;
		summarize();
	end
endmodule // tb
